// file: tec_ctrl_reg.sv
`timescale 1ns/1ns
`default_nettype none
module tec_ctrl_reg (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [11:0]          paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 t0_ovf,
  input  wire logic                 t1_ovf,
  input  wire logic                 t0_gate_in,
  input  wire logic                 t1_gate_in,
  input  wire logic                 t0_isr_enter,
  input  wire logic                 t1_isr_enter,
  input  wire logic                 x0_isr_enter,
  input  wire logic                 x1_isr_enter,
  input  wire logic                 ext_int0_n,
  input  wire logic                 ext_int1_n,
  output var  logic                 t0_count_en,
  output var  logic                 t1_count_en,
  output var  tec_pkg::tec_ctrl_t   ctrl,
  output var  logic                 irq
);
  import tec_pkg::*;

  tec_apb_req_t req;
  logic [7:0]   ctrl_q;
  logic [7:0]   ctrl_d;
  logic [7:0]   flags_prev_q;
  logic [3:0]   stat_q;
  logic [3:0]   stat_d;
  logic [3:0]   en_q;
  logic [3:0]   en_d;
  logic [1:0]   gate_q;
  logic [1:0]   gate_d;
  logic [3:0]   ev;
  logic [31:0]  rdata_d;
  logic         rdy_d;
  logic         err_d;
  logic         irq_d;
  logic         t0_en_d;
  logic         t1_en_d;
  logic         wr_go;
  logic [7:0]   ctrl_wmask;
  logic [7:0]   ctrl_wval;
  logic         x0_flag;
  logic         x1_flag;

  // ==========================================
  // Address decode helpers
  function automatic logic is_bit_alias(input logic [11:0] a);
    is_bit_alias = (a >= TEC_BIT_BASE) && (a < TEC_BIT_BASE + 12'h0020) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == TEC_CTRL_OFS) || (a == TEC_IRQ_STAT_OFS) || (a == TEC_IRQ_EN_OFS) ||
                (a == TEC_IRQ_CLR_OFS) || (a == TEC_GATE_OFS) || is_bit_alias(a);
  endfunction

  assign req = '{sel: psel, en: penable, wr: pwrite, addr: paddr, wdata: pwdata, strb: pstrb};

  // ==========================================
  // APB slave: answer registered one cycle after setup
  always_comb begin
    rdy_d   = req.sel & ~req.en;
    err_d   = req.sel & ~req.en & ~is_mapped(req.addr);
    rdata_d = 32'h0000_0000;
    if (req.sel && !req.en && !req.wr) begin
      if (req.addr == TEC_CTRL_OFS) rdata_d = {24'h00_0000, ctrl_q};
      else if (req.addr == TEC_IRQ_STAT_OFS) rdata_d = {28'h000_0000, stat_q};
      else if (req.addr == TEC_IRQ_EN_OFS) rdata_d = {28'h000_0000, en_q};
      else if (req.addr == TEC_GATE_OFS) rdata_d = {30'h0000_0000, gate_q};
      else if (is_bit_alias(req.addr))
        rdata_d = {31'h0000_0000, ctrl_q[req.addr[4:2]]};  // R01
    end
  end

  // Write commits on the access edge where pready is seen high
  assign wr_go = req.sel & req.en & req.wr & pready & ~pslverr & req.strb[0];

  // ==========================================
  // Control byte write mask: whole byte or one aliased bit
  always_comb begin
    ctrl_wmask = 8'h00;
    ctrl_wval  = 8'h00;
    if (wr_go && req.addr == TEC_CTRL_OFS) begin          // R01
      ctrl_wmask = 8'hff;
      ctrl_wval  = req.wdata[7:0];
    end else if (wr_go && is_bit_alias(req.addr)) begin    // R01
      ctrl_wmask = 8'h01 << req.addr[4:2];
      ctrl_wval  = {8{req.wdata[0]}};
    end
  end

  tec_ext_flag u_x0 (
    .pclk    (pclk),
    .presetn (presetn),
    .type_sel(ctrl_q[TEC_X0_TYP_BIT]),                     // R14
    .pin_n   (ext_int0_n),
    .hw_clr  (x0_isr_enter),
    .sw_we   (ctrl_wmask[TEC_X0_FLG_BIT]),
    .sw_val  (ctrl_wval[TEC_X0_FLG_BIT]),
    .flag_q  (x0_flag)
  );

  tec_ext_flag u_x1 (
    .pclk    (pclk),
    .presetn (presetn),
    .type_sel(ctrl_q[TEC_X1_TYP_BIT]),
    .pin_n   (ext_int1_n),
    .hw_clr  (x1_isr_enter),
    .sw_we   (ctrl_wmask[TEC_X1_FLG_BIT]),
    .sw_val  (ctrl_wval[TEC_X1_FLG_BIT]),
    .flag_q  (x1_flag)
  );

  // ==========================================
  // Control byte next state
  always_comb begin
    ctrl_d = (ctrl_q & ~ctrl_wmask) | (ctrl_wval & ctrl_wmask);
    // Overflow set beats both service entry clear and a software zero
    ctrl_d[TEC_T1_OVF_BIT] = t1_ovf |                                  // R02
      (ctrl_wmask[TEC_T1_OVF_BIT] ? ctrl_wval[TEC_T1_OVF_BIT] :        // R04
       (ctrl_q[TEC_T1_OVF_BIT] & ~t1_isr_enter));                      // R03
    ctrl_d[TEC_T0_OVF_BIT] = t0_ovf |                                  // R06
      (ctrl_wmask[TEC_T0_OVF_BIT] ? ctrl_wval[TEC_T0_OVF_BIT] :        // R04
       (ctrl_q[TEC_T0_OVF_BIT] & ~t0_isr_enter));                      // R07
    // Event flags live in the flag cells; this copy only mirrors them
    ctrl_d[TEC_X1_FLG_BIT] = x1_flag;
    ctrl_d[TEC_X0_FLG_BIT] = x0_flag;
  end

  // ==========================================
  // Timer enables, gate register, interrupt status
  always_comb begin
    gate_d = gate_q;
    if (wr_go && req.addr == TEC_GATE_OFS) gate_d = req.wdata[1:0];
    // A stopped timer simply gets no count enable, so its bytes hold
    t1_en_d = ctrl_d[TEC_T1_RUN_BIT] & (~gate_d[1] | t1_gate_in);  // R05 R15
    t0_en_d = ctrl_d[TEC_T0_RUN_BIT] & (~gate_d[0] | t0_gate_in);  // R08 R15
    en_d = en_q;
    if (wr_go && req.addr == TEC_IRQ_EN_OFS) en_d = req.wdata[3:0];
    ev = 4'h0;
    ev[TEC_EV_T0] = t0_ovf;
    ev[TEC_EV_T1] = t1_ovf;
    ev[TEC_EV_X0] = ctrl_q[TEC_X0_FLG_BIT] & ~flags_prev_q[TEC_X0_FLG_BIT];
    ev[TEC_EV_X1] = ctrl_q[TEC_X1_FLG_BIT] & ~flags_prev_q[TEC_X1_FLG_BIT];
    stat_d = stat_q;
    if (wr_go && req.addr == TEC_IRQ_CLR_OFS) stat_d = stat_q & ~req.wdata[3:0];
    stat_d = stat_d | ev;
    irq_d  = |(stat_d & en_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q       <= TEC_CTRL_RST;                        // R16
      flags_prev_q <= TEC_CTRL_RST;
      stat_q       <= TEC_IRQ_RST;
      en_q         <= TEC_IRQ_RST;
      gate_q       <= TEC_GATE_RST;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      irq          <= 1'b0;
      t0_count_en  <= 1'b0;
      t1_count_en  <= 1'b0;
      ctrl         <= TEC_CTRL_RST;
    end else begin
      ctrl_q       <= ctrl_d;
      flags_prev_q <= ctrl_q;
      stat_q       <= stat_d;
      en_q         <= en_d;
      gate_q       <= gate_d;
      prdata       <= rdata_d;
      pready       <= rdy_d;
      pslverr      <= err_d;
      irq          <= irq_d;
      t0_count_en  <= t0_en_d;
      t1_count_en  <= t1_en_d;
      ctrl         <= ctrl_d;
    end
  end

  // ==========================================
  // Checks
  t1_ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R02
    t1_ovf |=> ctrl_q[TEC_T1_OVF_BIT])
    else $error("timer one overflow did not set flag");
  t1_isr_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
    t1_isr_enter && !t1_ovf && !ctrl_wmask[TEC_T1_OVF_BIT]
      |=> !ctrl_q[TEC_T1_OVF_BIT])
    else $error("timer one service entry did not clear flag");
  sw_ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ctrl_wmask[TEC_T0_OVF_BIT] && ctrl_wval[TEC_T0_OVF_BIT] |=> ctrl_q[TEC_T0_OVF_BIT])
    else $error("software one did not set timer zero flag");
  t1_sw_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ctrl_wmask[TEC_T1_OVF_BIT] && ctrl_wval[TEC_T1_OVF_BIT] |=> ctrl_q[TEC_T1_OVF_BIT])
    else $error("software one did not set timer one flag");
  t0_sw_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ctrl_wmask[TEC_T0_OVF_BIT] && !ctrl_wval[TEC_T0_OVF_BIT] && !t0_ovf
      |=> !ctrl_q[TEC_T0_OVF_BIT])
    else $error("software zero did not clear timer zero flag");
  t1_sw_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R04
    ctrl_wmask[TEC_T1_OVF_BIT] && !ctrl_wval[TEC_T1_OVF_BIT] && !t1_ovf
      |=> !ctrl_q[TEC_T1_OVF_BIT])
    else $error("software zero did not clear timer one flag");
  t0_ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
    t0_ovf |=> ctrl_q[TEC_T0_OVF_BIT])
    else $error("timer zero overflow did not set flag");
  t0_isr_clr_a: assert property (@(posedge pclk) disable iff (!presetn) // R07
    t0_isr_enter && !t0_ovf && !ctrl_wmask[TEC_T0_OVF_BIT]
      |=> !ctrl_q[TEC_T0_OVF_BIT])
    else $error("timer zero service entry did not clear flag");
  // Status keeps the overflow even if software clears it in the same cycle
  stat_ovf_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
    t0_ovf |=> stat_q[TEC_EV_T0])
    else $error("timer zero overflow did not set status");
  t1_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // R05
    !ctrl_q[TEC_T1_RUN_BIT] |-> !t1_count_en)
    else $error("timer one enabled while run bit low");
  t0_halt_a: assert property (@(posedge pclk) disable iff (!presetn) // R08
    !ctrl_q[TEC_T0_RUN_BIT] |-> !t0_count_en)
    else $error("timer zero enabled while run bit low");
  t1_run_a: assert property (@(posedge pclk) disable iff (!presetn) // R05 R15
    ctrl_q[TEC_T1_RUN_BIT] && !gate_q[1] && !wr_go |=> t1_count_en)
    else $error("ungated timer one not enabled by run bit");
  t0_run_a: assert property (@(posedge pclk) disable iff (!presetn) // R08 R15
    ctrl_q[TEC_T0_RUN_BIT] && !gate_q[0] && !wr_go |=> t0_count_en)
    else $error("ungated timer zero not enabled by run bit");
  // A gate write in the same cycle may lift the gate, so it is left out
  gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    gate_q[0] && !t0_gate_in && !(wr_go && req.addr == TEC_GATE_OFS) |=> !t0_count_en)
    else $error("gated timer zero counted with gate low");
  t1_gate_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
    gate_q[1] && !t1_gate_in && !(wr_go && req.addr == TEC_GATE_OFS) |=> !t1_count_en)
    else $error("gated timer one counted with gate low");
  x0_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
    !ctrl_q[TEC_X0_TYP_BIT] ##1 !ctrl_q[TEC_X0_TYP_BIT]
      |=> ctrl_q[TEC_X0_FLG_BIT] == !$past(ext_int0_n, 2))
    else $error("level flag zero does not track input");
  x1_level_a: assert property (@(posedge pclk) disable iff (!presetn) // R11
    !ctrl_q[TEC_X1_TYP_BIT] ##1 !ctrl_q[TEC_X1_TYP_BIT]
      |=> ctrl_q[TEC_X1_FLG_BIT] == !$past(ext_int1_n, 2))
    else $error("level flag one does not track input");
  x0_edge_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    ctrl_q[TEC_X0_TYP_BIT] && x0_flag && !x0_isr_enter && !ctrl_wmask[TEC_X0_FLG_BIT]
      |=> x0_flag)
    else $error("edge flag zero dropped without a clear");
  x1_edge_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
    ctrl_q[TEC_X1_TYP_BIT] && x1_flag && !x1_isr_enter && !ctrl_wmask[TEC_X1_FLG_BIT]
      |=> x1_flag)
    else $error("edge flag one dropped without a clear");
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
    psel && !penable |=> pready ##1 !pready)
    else $error("APB answer not one cycle after setup");
  slverr_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
    psel && !penable && !is_mapped(paddr) |=> pslverr)
    else $error("unmapped address not refused");
  alias_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
    psel && !penable && !pwrite && paddr == TEC_BIT_BASE
      |=> prdata == {31'h0000_0000, $past(ctrl_q[TEC_X0_TYP_BIT])})
    else $error("bit alias read returned wrong bit");
endmodule
`default_nettype wire

// file: tec_ext_flag.sv
`timescale 1ns/1ns
`default_nettype none
module tec_ext_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic type_sel,
  input  wire logic pin_n,
  input  wire logic hw_clr,
  input  wire logic sw_we,
  input  wire logic sw_val,
  output var  logic flag_q
);
  logic prev_q;
  logic prev_d;
  logic flag_d;
  logic fall;

  always_comb begin
    prev_d = pin_n;
    fall   = prev_q & ~pin_n;
    if (type_sel) begin
      // Set wins over any clear arriving in the same cycle
      flag_d = fall | (sw_we & sw_val) |                   // R09 R12
               (flag_q & ~hw_clr & ~sw_we);                // R10
    end else begin
      flag_d = ~pin_n;                                     // R11 R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b1;
      flag_q <= 1'b0;                                      // R16
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  edge_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R09 R12
    type_sel && prev_q && !pin_n |=> flag_q)
    else $error("falling edge did not set event flag");
  level_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // R11 R13
    !type_sel |=> flag_q == !$past(pin_n))
    else $error("level flag does not follow inverted input");
endmodule
`default_nettype wire

// file: tec_pkg.sv
// How it works
// R01: The control byte sits at byte address 88H and every bit also has its own word alias.
// R02: A timer-one overflow pulse sets the timer-one overflow flag in bit 7.
// R03: Entry to the timer-one service routine clears the timer-one overflow flag.
// R04: Software may write either overflow flag to one or zero, and a one sets it like an overflow.
// R05: With the timer-one run bit (bit 6) low, timer one is stopped and keeps its count.
// R06: A timer-zero overflow pulse sets the timer-zero overflow flag in bit 5.
// R07: Entry to the timer-zero service routine clears the timer-zero overflow flag.
// R08: With the timer-zero run bit (bit 4) low, timer zero is stopped and keeps its count.
// R09: With interrupt-one type select at one, a falling edge on input one sets its event flag.
// R10: In edge mode an event flag stays set until software or service routine entry clears it.
// R11: With interrupt-one type select at zero, its flag follows the inverted input, unwritable.
// R12: With interrupt-zero type select at one, a falling edge on input zero sets its event flag.
// R13: With interrupt-zero type select at zero, its flag follows the inverted input, unwritable.
// R14: Bit 0 selects low-level (0) or falling-edge (1) triggering of external interrupt zero.
// R15: With gate control high a timer counts only while run is high and its gate input is high.
// R16: Reset clears run bits, overflow flags, event flags and type selects.
`default_nettype none
package tec_pkg;
  // ==========================================
  // Register map (byte addresses)
  localparam logic [11:0] TEC_CTRL_OFS     = 12'h0088;
  localparam logic [11:0] TEC_IRQ_STAT_OFS = 12'h008c;
  localparam logic [11:0] TEC_IRQ_EN_OFS   = 12'h0090;
  localparam logic [11:0] TEC_IRQ_CLR_OFS  = 12'h0094;
  localparam logic [11:0] TEC_GATE_OFS     = 12'h0098;
  localparam logic [11:0] TEC_BIT_BASE     = 12'h00a0;
  // ==========================================
  // Control byte field positions
  localparam int TEC_T1_OVF_BIT = 7;
  localparam int TEC_T1_RUN_BIT = 6;
  localparam int TEC_T0_OVF_BIT = 5;
  localparam int TEC_T0_RUN_BIT = 4;
  localparam int TEC_X1_FLG_BIT = 3;
  localparam int TEC_X1_TYP_BIT = 2;
  localparam int TEC_X0_FLG_BIT = 1;
  localparam int TEC_X0_TYP_BIT = 0;
  // ==========================================
  // Interrupt status positions and reset values
  localparam int TEC_EV_T0 = 0;
  localparam int TEC_EV_T1 = 1;
  localparam int TEC_EV_X0 = 2;
  localparam int TEC_EV_X1 = 3;
  localparam logic [7:0] TEC_CTRL_RST = 8'h00;
  localparam logic [3:0] TEC_IRQ_RST  = 4'h0;
  localparam logic [1:0] TEC_GATE_RST = 2'h0;

  typedef struct packed {
    logic timer_one_overflow_flag;
    logic timer_one_run_bit;
    logic timer_zero_overflow_flag;
    logic timer_zero_run_bit;
    logic interrupt_one_event_flag;
    logic interrupt_one_type_select;
    logic interrupt_zero_event_flag;
    logic interrupt_zero_type_select;
  } tec_ctrl_t;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0]  strb;
  } tec_apb_req_t;
endpackage
`default_nettype wire

// file: tec_tmr_model.sv
`timescale 1ns/1ns
`default_nettype none
module tec_tmr_model #(
  parameter int WRAP = 8
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  output var  logic       ovf,
  output var  logic [7:0] cnt
);
  // ==========================================
  // Short counter so overflows come within a few cycles
  localparam logic [7:0] LAST = 8'(WRAP - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      ovf <= 1'b0;
    end else begin
      ovf <= en && (cnt == LAST);
      if (en) begin
        cnt <= (cnt == LAST) ? 8'h00 : cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// file: timer_extint_control_reg_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timer_extint_control_reg_bench;
  import tec_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, irq;
  logic [1:0]  ovf, cen, isr_t = 2'h0, isr_x = 2'h0, gate_in = 2'h0, pin_n = 2'h3;
  logic [7:0]  cnt [2];
  logic [7:0]  cb, c;
  tec_ctrl_t   ctrl;
  int          num_errors = 0, checked = 0, cyc = 0, k;
  assign cb = ctrl;
  always #2 pclk = ~pclk;
  tec_ctrl_reg dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .t0_ovf(ovf[0]),
    .t1_ovf(ovf[1]), .t0_gate_in(gate_in[0]), .t1_gate_in(gate_in[1]),
    .t0_isr_enter(isr_t[0]), .t1_isr_enter(isr_t[1]), .x0_isr_enter(isr_x[0]),
    .x1_isr_enter(isr_x[1]), .ext_int0_n(pin_n[0]), .ext_int1_n(pin_n[1]),
    .t0_count_en(cen[0]), .t1_count_en(cen[1]), .ctrl(ctrl), .irq(irq));
  tec_tmr_model u_t0 (.pclk(pclk), .presetn(presetn), .en(cen[0]), .ovf(ovf[0]),
    .cnt(cnt[0]));
  tec_tmr_model u_t1 (.pclk(pclk), .presetn(presetn), .en(cen[1]), .ovf(ovf[1]),
    .cnt(cnt[1]));
  // ==========================================
  // Access tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Trailing edge keeps back-to-back calls from assigning psel twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // ==========================================
  // Tests
  initial begin
    tick(12);
    presetn <= 1'b1;
    tick(1);
    rdc(TEC_CTRL_OFS, 32'h0000_0000);
    rdc(TEC_GATE_OFS, 32'h0000_0000);
    check(cen, 2'h0);
    apb(1'b0, 12'h0ff, 32'h0000_0000);
    check(err, 1'b1);
    $display("reset and decode test done");
    for (int i = 0; i < 2; i++) begin
      wr(TEC_CTRL_OFS, i ? 8'h40 : 8'h10);
      check(cen, i ? 2'h2 : 2'h1);
      k = 0;
      while (cb[i ? 7 : 5] !== 1'b1 && k < 40) begin
        tick(1);
        k++;
      end
      check(cb[i ? 7 : 5], 1'b1);
      wr(TEC_CTRL_OFS, i ? 8'h80 : 8'h20);
      c = cnt[i];
      tick(6);
      check(cnt[i], c);
      check(cen, 2'h0);
      isr_t[i] <= 1'b1;
      tick(1);
      isr_t <= 2'h0;
      tick(2);
      rdc(TEC_CTRL_OFS, 32'h0000_0000);
    end
    $display("timer run and overflow test done");
    wr(TEC_GATE_OFS, 8'h03);
    wr(TEC_CTRL_OFS, 8'h50);
    check(cen, 2'h0);
    gate_in <= 2'h3;
    tick(3);
    check(cen, 2'h3);
    wr(TEC_CTRL_OFS, 8'h00);
    wr(TEC_GATE_OFS, 8'h00);
    wr(TEC_CTRL_OFS, 8'ha0);
    rdc(TEC_CTRL_OFS, 32'h0000_00a0);
    wr(TEC_CTRL_OFS, 8'h00);
    rdc(TEC_CTRL_OFS, 32'h0000_0000);
    wr(TEC_BIT_BASE + 12'h01c, 8'h01);
    rdc(TEC_CTRL_OFS, 32'h0000_0080);
    rdc(TEC_BIT_BASE + 12'h01c, 32'h0000_0001);
    wr(TEC_CTRL_OFS, 8'h00);
    $display("gate, software flag and alias test done");
    for (int i = 0; i < 2; i++) begin
      wr(TEC_IRQ_CLR_OFS, 8'h0f);
      wr(TEC_CTRL_OFS, i ? 8'h04 : 8'h01);
      pin_n[i] <= 1'b0;
      tick(3);
      check(cb[2 * i + 1], 1'b1);
      pin_n[i] <= 1'b1;
      tick(3);
      check(cb[2 * i + 1], 1'b1);
      rdc(TEC_IRQ_STAT_OFS, i ? 32'h0000_0008 : 32'h0000_0004);
      check(irq, 1'b0);
      wr(TEC_IRQ_EN_OFS, i ? 8'h08 : 8'h04);
      tick(2);
      check(irq, 1'b1);
      wr(TEC_IRQ_CLR_OFS, 8'h0f);
      tick(2);
      check(irq, 1'b0);
      isr_x[i] <= 1'b1;
      tick(1);
      isr_x <= 2'h0;
      tick(2);
      check(cb[2 * i + 1], 1'b0);
      // Edge mode: software may set and clear the event flag
      wr(TEC_CTRL_OFS, i ? 8'h0c : 8'h03);
      tick(1);
      check(cb[2 * i + 1], 1'b1);
      wr(TEC_CTRL_OFS, i ? 8'h04 : 8'h01);
      tick(1);
      check(cb[2 * i + 1], 1'b0);
      wr(TEC_CTRL_OFS, 8'h00);
      pin_n[i] <= 1'b0;
      tick(3);
      check(cb[2 * i + 1], 1'b1);
      wr(TEC_CTRL_OFS, 8'h00);
      tick(2);
      check(cb[2 * i + 1], 1'b1);
      pin_n[i] <= 1'b1;
      tick(3);
      check(cb[2 * i + 1], 1'b0);
      wr(TEC_CTRL_OFS, i ? 8'h08 : 8'h02);
      tick(2);
      check(cb[2 * i + 1], 1'b0);
      wr(TEC_IRQ_EN_OFS, 8'h00);
    end
    $display("external interrupt test done");
    wrap_up();
  end
endmodule
`default_nettype wire
